/* File: common/clk_gate_pkg.sv */
package clk_gate_pkg;
    // register addresses on the plain register port
    localparam logic [7:0] ADDR_GATE_1 = 8'hDB;
    localparam logic [7:0] ADDR_GATE_2 = 8'hDC;
    localparam logic [7:0] RESET_GATE_1 = 8'h00;
    localparam logic [7:0] RESET_GATE_2 = 8'h00;
    // writable bits of the second register, bits 5:4 reserved
    localparam logic [7:0] MASK_GATE_2 = 8'hCF;
    // field positions, first register
    localparam int BIT_PORT_D = 7;
    localparam int BIT_PORT_C = 6;
    localparam int BIT_PORT_B = 5;
    localparam int BIT_PORT_A = 4;
    localparam int BIT_SPI = 3;
    localparam int BIT_TWI = 2;
    localparam int BIT_SERIAL_SECOND = 1;
    localparam int BIT_SERIAL_FIRST = 0;
    // field positions, second register
    localparam int BIT_CLKOUT_DIS = 7;
    localparam int BIT_BROWNOUT_DIS = 6;
    localparam int BIT_COUNTER_LO = 0;
    // number of gated peripherals: 8 from register 1, 4 timers
    localparam int NUM_GATES = 12;
    // peripheral index space for access blocking
    localparam int PERIPH_W = 4;
endpackage : clk_gate_pkg

/* File: rtl/access_block.sv */
`timescale 1ns/1ps
// passes peripheral register strobes only while its clock runs
module access_block (
    input wire logic gated_off,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic wr_out,
    output logic rd_out
);
    // a stopped peripheral cannot complete an access, so drop it
    assign wr_out = wr_in & ~gated_off;
    assign rd_out = rd_in & ~gated_off;
endmodule : access_block

/* File: rtl/glitchless_gate.sv */
`timescale 1ns/1ps
// latch-based clock gate: enable is captured while clk is low
module glitchless_gate (
    input wire logic clk,
    input wire logic en,
    output logic gclk
);
    logic en_latched;

    // transparent while clk low, so enable cannot change mid high phase
    always_latch begin
        if (!clk) begin
            en_latched <= en;
        end
    end

    assign gclk = clk & en_latched;
endmodule : glitchless_gate

/* File: rtl/peripheral_clock_gating.sv */
`timescale 1ns/1ps
module peripheral_clock_gating (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // gated clocks: [7:4] ports D..A, 3 spi, 2 twi, 1/0 serial, [11:8] ctr
    output logic [clk_gate_pkg::NUM_GATES-1:0] gclk,
    // per-peripheral access strobes, index as gclk
    input wire logic [clk_gate_pkg::NUM_GATES-1:0] p_wr,
    input wire logic [clk_gate_pkg::NUM_GATES-1:0] p_rd,
    output logic [clk_gate_pkg::NUM_GATES-1:0] p_wr_ok,
    output logic [clk_gate_pkg::NUM_GATES-1:0] p_rd_ok,
    // clock output pin and brownout control
    input wire logic clock_src,
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe,
    output logic brownout_detector_en
);
    logic [7:0] peripheral_clock_gate_1_r;
    logic [7:0] peripheral_clock_gate_2_r;
    logic [7:0] rdata_r;
    logic [clk_gate_pkg::NUM_GATES-1:0] gate_off;
    // decoded selects, bit 0 first register, bit 1 second register
    logic [1:0] sel;

    // address decode shared by write and read paths
    function automatic logic [1:0] decode(input logic [7:0] a);
        decode = {a == clk_gate_pkg::ADDR_GATE_2,
                  a == clk_gate_pkg::ADDR_GATE_1};
    endfunction : decode

    // one decode shared by all paths, a call result cannot be bit-selected
    assign sel = decode(addr);

    // first register: bits change only on reset or a software write
    always_ff @(posedge clk) begin
        if (srst) begin
            peripheral_clock_gate_1_r <= clk_gate_pkg::RESET_GATE_1;
        end else if (ce && wr && sel[0]) begin
            peripheral_clock_gate_1_r <= wdata;
        end
    end

    // second register: reserved bits forced to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            peripheral_clock_gate_2_r <= clk_gate_pkg::RESET_GATE_2;
        end else if (ce && wr && sel[1]) begin
            peripheral_clock_gate_2_r <=
                wdata & clk_gate_pkg::MASK_GATE_2;
        end
    end

    // read data valid the cycle after the strobe, zero otherwise, held while ce is low
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            if (rd && sel[0]) begin
                rdata_r <= peripheral_clock_gate_1_r;
            end else if (rd && sel[1]) begin
                rdata_r <= peripheral_clock_gate_2_r;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end
    assign rdata = rdata_r;

    // gate vector: first register bits map one to one
    assign gate_off[7:0] = peripheral_clock_gate_1_r;
    assign gate_off[11:8] =
        peripheral_clock_gate_2_r[clk_gate_pkg::BIT_COUNTER_LO +: 4];

    // one glitch-free gate and one access filter per peripheral
    genvar g;
    generate
        for (g = 0; g < clk_gate_pkg::NUM_GATES; g++) begin : gen_gate
            glitchless_gate u_gate (
                .clk(clk),
                .en(~gate_off[g]),
                .gclk(gclk[g])
            );
            access_block u_blk (
                .gated_off(gate_off[g]),
                .wr_in(p_wr[g]),
                .rd_in(p_rd[g]),
                .wr_out(p_wr_ok[g]),
                .rd_out(p_rd_ok[g])
            );
        end
    endgenerate

    // clock output pin tristated when disabled
    assign clock_output_pin_o = clock_src;
    assign clock_output_pin_oe =
        ~peripheral_clock_gate_2_r[clk_gate_pkg::BIT_CLKOUT_DIS];
    // power-on reset is outside this block and stays unaffected
    assign brownout_detector_en =
        ~peripheral_clock_gate_2_r[clk_gate_pkg::BIT_BROWNOUT_DIS];

    // reset leaves every peripheral running
    reset_clear_a: assert property (@(posedge clk)
        srst |=> (peripheral_clock_gate_1_r == 8'h00 &&
                  peripheral_clock_gate_2_r == 8'h00))
        else $error("gating registers not cleared by reset");

    write_one_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wr && addr == 8'hDB && wdata[3]) |=> gate_off[3])
        else $error("write of one did not gate peripheral");

    stay_off_a: assert property (@(posedge clk) disable iff (srst)
        (gate_off[0] && !(ce && wr && addr == 8'hDB)) |=> gate_off[0])
        else $error("peripheral re-enabled without a write");

    access_blocked_a: assert property (@(posedge clk)
        (gate_off[5] && p_wr[5]) |-> !p_wr_ok[5])
        else $error("access to gated peripheral passed");

    timer_map_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wr && addr == 8'hDC) |=> (gate_off[11:8] == $past(wdata[3:0])))
        else $error("counter gates do not follow register");

    clkout_dis_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wr && addr == 8'hDC && wdata[7]) |=> !clock_output_pin_oe)
        else $error("clock output still driven");

    brownout_off_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wr && addr == 8'hDC) |=> brownout_detector_en == !$past(wdata[6]))
        else $error("brownout enable wrong");

    reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
        (ce && rd && addr == 8'hDC) |=> rdata[5:4] == 2'b00)
        else $error("reserved bits read nonzero");

    read_back_a: assert property (@(posedge clk) disable iff (srst)
        (ce && rd && addr == 8'hDB) |=> rdata == $past(peripheral_clock_gate_1_r))
        else $error("register readback mismatch");

    // second register reads back what was stored in it
    read_two_a: assert property (@(posedge clk) disable iff (srst)
        (ce && rd && addr == 8'hDC) |=>
            rdata == $past(peripheral_clock_gate_2_r))
        else $error("second register readback mismatch");

    // read data stand one cycle only while ce is high, then drop to zero
    rdata_idle_a: assert property (@(posedge clk) disable iff (srst)
        (ce && !rd) |=> rdata == 8'h00)
        else $error("read data not cleared after read");

    // reset also clears the read data
    rdata_reset_a: assert property (@(posedge clk)
        srst |=> rdata == 8'h00)
        else $error("read data not cleared by reset");

    // after reset every gate is open
    gates_reset_a: assert property (@(posedge clk)
        srst |=> gate_off == '0)
        else $error("gate left closed after reset");

    // after reset the pin is driven and the detector armed
    pins_reset_a: assert property (@(posedge clk)
        srst |=> (clock_output_pin_oe && brownout_detector_en))
        else $error("pin or detector wrong after reset");

    // clock enable low freezes the first register
    freeze_one_a: assert property (@(posedge clk) disable iff (srst)
        !ce |=> $stable(peripheral_clock_gate_1_r))
        else $error("first register moved while frozen");

    // clock enable low freezes the second register
    freeze_two_a: assert property (@(posedge clk) disable iff (srst)
        !ce |=> $stable(peripheral_clock_gate_2_r))
        else $error("second register moved while frozen");

    // writes elsewhere leave the first register alone
    other_wr_one_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wr && addr != 8'hDB) |=> $stable(peripheral_clock_gate_1_r))
        else $error("first register hit by foreign write");

    // writes elsewhere leave the second register alone
    other_wr_two_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wr && addr != 8'hDC) |=> $stable(peripheral_clock_gate_2_r))
        else $error("second register hit by foreign write");

    // reserved bits never hold a one, whatever was written
    reserved_hold_a: assert property (@(posedge clk)
        peripheral_clock_gate_2_r[5:4] == 2'b00)
        else $error("reserved bits stored a one");

    // clearing the disable bit drives the pin again
    clkout_on_a: assert property (@(posedge clk) disable iff (srst)
        (ce && wr && addr == 8'hDC && !wdata[7]) |=> clock_output_pin_oe)
        else $error("clock output not driven");

    // the pin carries the source clock whenever it is driven
    pin_follow_a: assert property (@(posedge clk)
        clock_output_pin_o == clock_src)
        else $error("clock output does not follow source");

    // per-bit checks for the first register's gates
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : gen_chk_one
            // each written bit lands on its own gate
            bit_one_a: assert property (@(posedge clk)
                disable iff (srst)
                (ce && wr && addr == 8'hDB) |=>
                    gate_off[b] == $past(wdata[b]))
                else $error("first register gate mismatch");

            // a closed gate stays closed until its register is written
            hold_one_a: assert property (@(posedge clk)
                disable iff (srst)
                (gate_off[b] && !(ce && wr && addr == 8'hDB)) |=>
                    gate_off[b])
                else $error("gate reopened without a write");

            // writing zero reopens the gate
            resume_one_a: assert property (@(posedge clk)
                disable iff (srst)
                (ce && wr && addr == 8'hDB && !wdata[b]) |=> !gate_off[b])
                else $error("gate not reopened by clear");
        end
    endgenerate

    // per-bit checks for the counter gates in the second register
    genvar t;
    generate
        for (t = 0; t < 4; t++) begin : gen_chk_two
            // a closed counter gate waits for a write to reopen
            hold_two_a: assert property (@(posedge clk)
                disable iff (srst)
                (gate_off[8 + t] && !(ce && wr && addr == 8'hDC)) |=>
                    gate_off[8 + t])
                else $error("counter gate reopened without a write");

            // writing one closes the counter gate
            close_two_a: assert property (@(posedge clk)
                disable iff (srst)
                (ce && wr && addr == 8'hDC && wdata[t]) |=> gate_off[8 + t])
                else $error("counter gate not closed");
        end
    endgenerate

    // strobe filters for every peripheral
    genvar s;
    generate
        for (s = 0; s < clk_gate_pkg::NUM_GATES; s++) begin : gen_chk_blk
            // a stopped peripheral sees neither read nor write
            stop_block_a: assert property (@(posedge clk)
                gate_off[s] |-> (!p_wr_ok[s] && !p_rd_ok[s]))
                else $error("strobe passed to gated peripheral");

            // a running peripheral sees its strobes unchanged
            run_pass_a: assert property (@(posedge clk)
                !gate_off[s] |->
                    (p_wr_ok[s] == p_wr[s] && p_rd_ok[s] == p_rd[s]))
                else $error("strobe lost at running peripheral");
        end
    endgenerate
endmodule : peripheral_clock_gating

/* File: tb/periph_model.sv */
`timescale 1ns/1ps
// gated peripherals: each flips its bit on every rising clock edge it receives
module periph_model (
    input wire logic [11:0] gclk,
    output logic [11:0] alive
);
    initial alive = 12'h000;
    // a stopped clock leaves its bit frozen, so activity is easy to see
    for (genvar i = 0; i < 12; i++) begin : g_p
        always @(posedge gclk[i]) alive[i] <= ~alive[i];
    end
endmodule : periph_model

/* File: tb/peripheral_clock_gating_test.sv */
`timescale 1ns/1ps
// random register traffic with checks of every gate and strobe filter
module peripheral_clock_gating_test;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r1 = 8'h00, r2 = 8'h00;
    logic [11:0] gclk, p_wr = 12'h000, p_rd = 12'h000, p_wr_ok, p_rd_ok;
    logic [11:0] alive, snap, off;
    logic clock_src = 1'b0, clock_output_pin_o, clock_output_pin_oe;
    logic brownout_detector_en;
    int fails = 0, n_tests = 0;
    initial forever #12.5 clk = ~clk;
    peripheral_clock_gating u_peripheral_clock_gating (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .gclk(gclk),
        .p_wr(p_wr),
        .p_rd(p_rd),
        .p_wr_ok(p_wr_ok),
        .p_rd_ok(p_rd_ok),
        .clock_src(clock_src),
        .clock_output_pin_o(clock_output_pin_o),
        .clock_output_pin_oe(clock_output_pin_oe),
        .brownout_detector_en(brownout_detector_en)
    );
    periph_model u_periph_model (.gclk(gclk), .alive(alive));
    task automatic compare(string nm, logic [11:0] e, logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : compare
    task automatic finish_test();
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // unmapped addresses read as zero
    function automatic logic [7:0] exp_rd(logic [7:0] a);
        return a == 8'hDB ? r1 : (a == 8'hDC ? r2 : 8'h00);
    endfunction : exp_rd
    task automatic wr_reg(logic [7:0] a, logic [7:0] d, logic e);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        ce <= e;
        @(posedge clk);
        wr <= 1'b0;
        ce <= 1'b1;
        // reserved bits 5:4 never stick
        if (e && a == 8'hDB) r1 = d;
        if (e && a == 8'hDC) r2 = d & 8'hCF;
    endtask : wr_reg
    task automatic rd_reg(logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        compare("rdata", {4'h0, exp_rd(a)}, {4'h0, rdata});
    endtask : rd_reg
    // odd edge count over three cycles means the clock kept running
    task automatic check_gates();
        off = {r2[3:0], r1};
        repeat (2) @(posedge clk);
        p_wr <= 12'($urandom);
        p_rd <= 12'($urandom);
        clock_src <= 1'($urandom);
        #1;
        snap = alive;
        repeat (3) @(posedge clk);
        #1;
        compare("running", ~off, alive ^ snap);
        compare("wr_ok", p_wr & ~off, p_wr_ok);
        compare("rd_ok", p_rd & ~off, p_rd_ok);
        compare("pin", {10'h0, ~r2[7], clock_src},
            {10'h0, clock_output_pin_oe, clock_output_pin_o});
        compare("bod", {11'h0, ~r2[6]}, {11'h0, brownout_detector_en});
    endtask : check_gates
    initial begin
        logic [7:0] a;
        void'($urandom(79837));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd_reg(8'hDB);
        rd_reg(8'hDC);
        check_gates();
        wr_reg(8'hDB, 8'hFF, 1'b1);
        wr_reg(8'hDC, 8'hFF, 1'b1);
        check_gates();
        for (int i = 0; i < 40; i++) begin
            a = (i % 3 == 0) ? 8'($urandom) : ((i % 3 == 1) ? 8'hDB : 8'hDC);
            wr_reg(a, 8'($urandom), ($urandom % 6) != 0);
            rd_reg(8'hDB);
            rd_reg(8'hDC);
            check_gates();
        end
        // reset in mid-run must bring every clock back
        wr_reg(8'hDB, 8'hFF, 1'b1);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        r1 = 8'h00;
        r2 = 8'h00;
        check_gates();
        rd_reg(8'hDB);
        finish_test();
    end
    // watchdog: the run needs well under a thousand cycles
    initial begin
        #100us;
        fails++;
        finish_test();
    end
endmodule : peripheral_clock_gating_test
